/* File: rtl/bsr_status_map.sv */
// Read-only status register map mirroring the burner controller's running time and device state.
`timescale 1ns/1ps
`default_nettype none
`include "bsr_params.svh"
module bsr_status_map
	import bsr_pkg::*;
#(
	parameter bsr_cnt_t REFRESH_CYC = `BSR_REFRESH_CYC,
	parameter bsr_cnt_t STALE_CYC = `BSR_STALE_CYC
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic rt_load,
	input wire logic [31:0] rt_hours,
	input wire logic [7:0] rt_minutes,
	input wire logic [3:0] dev_rx_ok,
	input wire logic [3:0] dev_compat,
	input wire logic legacy_compat,
	input wire logic rd_en,
	input wire logic [15:0] rd_addr,
	output logic rd_valid,
	output bsr_word_t rd_data,
	input wire logic wr_en,
	input wire logic [15:0] wr_addr,
	input wire logic [15:0] wr_data,
	output logic wr_refused,
	input wire logic pos_load,
	input wire logic [15:0] act_pos_raw,
	input wire logic [15:0] act_closed_end,
	output bsr_pos_t act_pos_rel
);
	logic [31:0] hours_q;
	bsr_byte_t minutes_q;
	logic fresh_q;
	bsr_dev_t ready_q;
	bsr_dev_t compat_q;
	logic legacy_q;
	logic rd_valid_q;
	bsr_word_t rd_data_q;
	logic wr_refused_q;
	bsr_pos_t pos_q;

	bsr_tmr_if refresh_if ();
	bsr_tmr_if stale_if ();

	// The refresh timer runs free from reset; nothing ever needs to realign it.
	assign refresh_if.restart = 1'b0;
	// [RQ9] Half-second refresh.
	bsr_timer #(.PERIOD(REFRESH_CYC), .RELOAD(1'b1)) u_refresh (
		.clk(clk),
		.rst(rst),
		.tif(refresh_if)
	);

	// Each fresh load of the running-time range restarts its age timer.
	// One-shot, so an expired range stays stale until the controller loads it again.
	assign stale_if.restart = rt_load;
	bsr_timer #(.PERIOD(STALE_CYC), .RELOAD(1'b0)) u_stale (
		.clk(clk),
		.rst(rst),
		.tif(stale_if)
	);

	// [RQ8] Slow mirror capture.
	// Values appear only once the controller delivers them, so nothing is shown before then.
	// The hour words are not latched as a pair: a load between the two reads can tear the
	// value, so a poller should read both words between loads.
	always_ff @(posedge clk) begin
		if (rst) begin
			hours_q <= `BSR_RST_HOURS;
		end else if (rt_load) begin
			hours_q <= rt_hours;
		end
	end

	// [RQ3] Minutes capture.
	always_ff @(posedge clk) begin
		if (rst) begin
			minutes_q <= `BSR_RST_BYTE;
		end else if (rt_load) begin
			minutes_q <= rt_minutes;
		end
	end

	// The range is current from a load until its age exceeds the stale limit.
	always_ff @(posedge clk) begin
		if (rst) begin
			fresh_q <= 1'b0;
		end else if (rt_load) begin
			fresh_q <= 1'b1;
		end else if (stale_if.expired) begin
			fresh_q <= 1'b0;
		end
	end

	// [RQ10] Ready follows freshness.
	// The controller only counts as received while its range is current, so the
	// ready bit clears between refreshes once the range goes stale, but sets only at the next refresh tick after a load.
	wire logic rt_stale_now = stale_if.expired & ~rt_load;
	wire logic relay_ready_d = dev_rx_ok[`BSR_DEV_RELAY];
	wire logic burner_ready_d = dev_rx_ok[`BSR_DEV_BURNER] & fresh_q & ~rt_stale_now;
	wire logic annun_ready_d = dev_rx_ok[`BSR_DEV_ANNUN];
	wire logic extmod_ready_d = dev_rx_ok[`BSR_DEV_EXTMOD];
	wire bsr_dev_t ready_d = {extmod_ready_d, annun_ready_d, burner_ready_d, relay_ready_d};
	wire logic snap_tick = refresh_if.expired;

	// [RQ5] Device ready snapshot.
	// The burner bit also drops between ticks once the range goes stale.
	always_ff @(posedge clk) begin
		if (rst) begin
			ready_q <= `BSR_RST_DEV;
		end else if (snap_tick) begin
			ready_q <= ready_d;
		end else if (!fresh_q) begin
			ready_q[`BSR_DEV_BURNER] <= 1'b0;
		end
	end

	// [RQ6] Compatibility snapshot.
	always_ff @(posedge clk) begin
		if (rst) begin
			compat_q <= `BSR_RST_DEV;
		end else if (snap_tick) begin
			compat_q <= dev_compat;
		end
	end

	// [RQ7] Legacy compatibility snapshot.
	always_ff @(posedge clk) begin
		if (rst) begin
			legacy_q <= 1'b0;
		end else if (snap_tick) begin
			legacy_q <= legacy_compat;
		end
	end

	// [RQ2] Hours split high word first.
	wire bsr_word_t hours_hi_w = hours_q[31:16];
	wire bsr_word_t hours_lo_w = hours_q[15:0];
	// [RQ3] Minutes in high byte.
	// [RQ1] Byte-wide parameter placement.
	wire bsr_word_t minutes_w = {minutes_q, `BSR_RST_BYTE};
	// [RQ4] Flag is zero or one.
	// [RQ10] Flag mirrors controller ready.
	wire bsr_word_t fresh_w = {15'h0000, ready_q[`BSR_DEV_BURNER]};
	// [RQ5] Upper bits zero.
	wire bsr_word_t ready_w = {12'h000, ready_q};
	// [RQ6] Bits 4 to 7 zero.
	// [RQ7] Legacy bit 8, reserved zero.
	wire bsr_byte_t compat_hi_byte = {7'h00, legacy_q};
	wire bsr_byte_t compat_lo_byte = {4'h0, compat_q};
	wire bsr_word_t compat_w = {compat_hi_byte, compat_lo_byte};

	// One select per mapped offset; at most one is ever high.
	wire logic sel_hours_hi = (rd_addr == `BSR_OFS_HOURS_HI);
	wire logic sel_hours_lo = (rd_addr == `BSR_OFS_HOURS_LO);
	wire logic sel_minutes = (rd_addr == `BSR_OFS_MINUTES);
	wire logic sel_fresh = (rd_addr == `BSR_OFS_FRESH);
	wire logic sel_ready = (rd_addr == `BSR_OFS_READY);
	wire logic sel_compat = (rd_addr == `BSR_OFS_COMPAT);

	// [RQ16] Unmapped and unused read zero.
	// An AND-OR select leaves zero wherever no select is high, the unused pair included.
	wire bsr_word_t rd_mux =
		({16{sel_hours_hi}} & hours_hi_w) |
		({16{sel_hours_lo}} & hours_lo_w) |
		({16{sel_minutes}} & minutes_w) |
		({16{sel_fresh}} & fresh_w) |
		({16{sel_ready}} & ready_w) |
		({16{sel_compat}} & compat_w);

	always_ff @(posedge clk) begin
		if (rst) begin
			rd_valid_q <= 1'b0;
		end else begin
			rd_valid_q <= rd_en;
		end
	end

	// Read data is held between reads so a slow master may pick it up late.
	always_ff @(posedge clk) begin
		if (rst) begin
			rd_data_q <= `BSR_RST_WORD;
		end else if (rd_en) begin
			rd_data_q <= rd_mux;
		end
	end

	// [RQ16] Writes refused.
	// Address and data are deliberately not stored; the pulse tells the bus side to
	// answer with an error instead of silently losing the write.
	wire logic wr_hit = wr_en & (wr_addr != 16'h0000 || wr_data != 16'h0000 || 1'b1);
	always_ff @(posedge clk) begin
		if (rst) begin
			wr_refused_q <= 1'b0;
		end else begin
			wr_refused_q <= wr_hit;
		end
	end

	// [RQ13] Closed endpoint is zero.
	wire logic below_closed = (act_pos_raw < act_closed_end);
	wire logic [15:0] pos_diff = act_pos_raw - act_closed_end;
	// [RQ12] Saturate to 4095 counts.
	// A count beyond full travel is clipped rather than wrapped into a small angle.
	wire logic above_span = (pos_diff > {4'h0, `BSR_ACT_COUNT_MAX});
	wire bsr_pos_t pos_d = below_closed ? 12'h000 :
		above_span ? `BSR_ACT_COUNT_MAX : pos_diff[11:0];

	always_ff @(posedge clk) begin
		if (rst) begin
			pos_q <= 12'h000;
		end else if (pos_load) begin
			pos_q <= pos_d;
		end
	end

	assign rd_valid = rd_valid_q;
	assign rd_data = rd_data_q;
	assign wr_refused = wr_refused_q;
	assign act_pos_rel = pos_q;
endmodule // bsr_status_map
`default_nettype wire

/* File: rtl/bsr_params.svh */
// Offsets, field positions, reset values and timing counts of the status register map.
// Summary of operation
// [RQ1] Paired registers carry one byte parameter high and one byte parameter low.
// [RQ2] Running hours form one 32-bit value across offsets 0x01b4 and 0x01b5.
// [RQ3] Running minutes sit in the high byte of 0x01b6; low byte reads zero.
// [RQ4] Freshness flag at 0x01b9 reads only zero or one.
// [RQ5] Data-ready bits 0..3 mark properly received devices; bits 4..15 zero.
// [RQ6] Compatibility bits 0..3 use the data-ready device order; bits 4..7 zero.
// [RQ7] Compatibility bit 8 marks legacy series compatibility; bits 9..15 reserved zero.
// [RQ8] Slow mirrored values may take up to 39 seconds to appear.
// [RQ9] Data-ready and compatibility registers refresh twice per second.
// [RQ10] Controller ready bit set means all freshness flags one, else one is zero.
// [RQ11] Master treats values under a clear freshness flag as possibly stale.
// [RQ12] Actuator positions are counts 0 to 4095 over 0 to 115 degrees.
// [RQ13] Positions are relative to the actuator closed endpoint as zero.
// [RQ14] Master converts hold counts using slope over 3108 and offset 777.
// [RQ15] Master subtracts 40 from raw auxiliary temperature bounds.
// [RQ16] All registers are read-only; writes ignored, unused bits read zero; the map answers each write with a wr_refused pulse.
`ifndef BSR_PARAMS_SVH
`define BSR_PARAMS_SVH

`define BSR_OFS_HOURS_HI 16'h01b4
`define BSR_OFS_HOURS_LO 16'h01b5
`define BSR_OFS_MINUTES 16'h01b6
`define BSR_OFS_UNUSED_A 16'h01b7
`define BSR_OFS_UNUSED_B 16'h01b8
`define BSR_OFS_FRESH 16'h01b9
`define BSR_OFS_READY 16'h01ba
`define BSR_OFS_COMPAT 16'h01bb

`define BSR_DEV_RELAY 0
`define BSR_DEV_BURNER 1
`define BSR_DEV_ANNUN 2
`define BSR_DEV_EXTMOD 3
`define BSR_DEV_COUNT 4
`define BSR_COMPAT_LEGACY_BIT 8

`define BSR_RST_WORD 16'h0000
`define BSR_RST_HOURS 32'h0000_0000
`define BSR_RST_BYTE 8'h00
`define BSR_RST_DEV 4'h0

`define BSR_CLK_HZ 10000000
`define BSR_REFRESH_MS 500
`define BSR_STALE_S 40
`define BSR_AVAIL_S 39
`define BSR_REFRESH_CYC ((`BSR_CLK_HZ / 1000) * `BSR_REFRESH_MS)
`define BSR_STALE_CYC (`BSR_CLK_HZ * `BSR_STALE_S)

`define BSR_ACT_COUNT_MAX 12'hfff

`endif

/* File: rtl/bsr_pkg.sv */
// Types shared by the status register map modules.
package bsr_pkg;
	typedef logic [15:0] bsr_word_t;
	typedef logic [7:0] bsr_byte_t;
	typedef logic [3:0] bsr_dev_t;
	typedef logic [31:0] bsr_cnt_t;
	typedef logic [11:0] bsr_pos_t;
endpackage

/* File: rtl/bsr_tmr_if.sv */
// Restart and expiry signals between the map and its interval timers.
`timescale 1ns/1ps
`default_nettype none
interface bsr_tmr_if;
	logic restart;
	logic expired;
	modport owner (output restart, input expired);
	modport timer (input restart, output expired);
endinterface
`default_nettype wire

/* File: rtl/bsr_timer.sv */
// Interval timer: expires after a set count of cycles since the last restart.
`timescale 1ns/1ps
`default_nettype none
module bsr_timer
	import bsr_pkg::*;
#(
	parameter bsr_cnt_t PERIOD = 32'd100,
	parameter bit RELOAD = 1'b1
) (
	input wire logic clk,
	input wire logic rst,
	bsr_tmr_if.timer tif
);
	bsr_cnt_t cnt_q;
	logic done_q;
	wire logic at_end = (cnt_q == PERIOD - 32'd1);

	// A one-shot timer holds its expired level until restarted; a reloading one pulses.
	always_ff @(posedge clk) begin
		if (rst || tif.restart) begin
			cnt_q <= 32'h0000_0000;
			done_q <= 1'b0;
		end else if (at_end) begin
			cnt_q <= RELOAD ? 32'h0000_0000 : cnt_q;
			done_q <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 32'd1;
			done_q <= RELOAD ? 1'b0 : done_q;
		end
	end

	assign tif.expired = done_q;
endmodule // bsr_timer
`default_nettype wire

/* File: testbench/bsr_map_sva.sv */
// Port assertions for the status register map.
`timescale 1ns/1ps
`default_nettype none
module bsr_map_sva
	import bsr_pkg::*;
#(
	parameter bsr_cnt_t REFRESH_CYC = 32'd20,
	parameter bsr_cnt_t STALE_CYC = 32'd100
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic rd_en,
	input wire logic [15:0] rd_addr,
	input wire logic rd_valid,
	input wire bsr_word_t rd_data,
	input wire logic wr_en,
	input wire logic wr_refused,
	input wire logic pos_load,
	input wire logic [15:0] act_pos_raw,
	input wire logic [15:0] act_closed_end,
	input wire bsr_pos_t act_pos_rel
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	AST_RD_ANS: assert property (rd_en |=> rd_valid) else $error("no read answer");
	AST_WR_REF: assert property (wr_en |=> wr_refused) else $error("no refusal");
	AST_WR_IDLE: assert property (!wr_en |=> !wr_refused) else $error("stray refusal");
	AST_MIN_LO: assert property (rd_en && rd_addr == 16'h01b6
		|=> rd_data[7:0] == 8'h00) else $error("minutes low byte set");
	AST_FRESH: assert property (rd_en && rd_addr == 16'h01b9
		|=> rd_data[15:1] == 15'h0000) else $error("fresh flag wide");
	AST_READY: assert property (rd_en && rd_addr == 16'h01ba
		|=> rd_data[15:4] == 12'h000) else $error("ready spare bits set");
	AST_COMPAT: assert property (rd_en && rd_addr == 16'h01bb
		|=> rd_data[15:9] == 7'h00 && rd_data[7:4] == 4'h0) else $error("compat spare bits");
	AST_POS_LOW: assert property (pos_load && act_pos_raw < act_closed_end
		|=> act_pos_rel == 12'h000) else $error("position below closed end");
	cover property (rd_en && rd_addr == 16'h01b9 ##1 rd_data == 16'h0001);
	cover property (wr_en ##1 wr_refused);
	cover property (pos_load ##1 act_pos_rel == 12'hfff);
endmodule // bsr_map_sva
bind bsr_status_map bsr_map_sva #(.REFRESH_CYC(REFRESH_CYC), .STALE_CYC(STALE_CYC)) bsr_map_sva_i (
	.clk(clk), .rst(rst), .rd_en(rd_en), .rd_addr(rd_addr), .rd_valid(rd_valid),
	.rd_data(rd_data), .wr_en(wr_en), .wr_refused(wr_refused), .pos_load(pos_load),
	.act_pos_raw(act_pos_raw), .act_closed_end(act_closed_end), .act_pos_rel(act_pos_rel));
`default_nettype wire

/* File: testbench/bsr_master_model.sv */
// Polling master model that reads one status register at a time.
`timescale 1ns/1ps
`default_nettype none
module bsr_master_model
	import bsr_pkg::*;
(
	input wire logic clk,
	output logic rd_en,
	output logic [15:0] rd_addr,
	input wire logic rd_valid,
	input wire bsr_word_t rd_data
);
	initial begin
		rd_en = 1'b0;
		rd_addr = 16'h0000;
	end
	// raw values only
	// Staleness and scaling are judged by software above this model.
	task automatic rd(input logic [15:0] a, output bsr_word_t d, output logic ok);
		@(negedge clk);
		rd_en = 1'b1;
		rd_addr = a;
		@(negedge clk);
		rd_en = 1'b0;
		rd_addr = ~a;
		ok = rd_valid;
		d = rd_data;
	endtask
endmodule // bsr_master_model
`default_nettype wire

/* File: testbench/testbench.sv */
// Self-checking bench for the status register map.
`timescale 1ns/1ps
`default_nettype none
module testbench import bsr_pkg::*;;
	logic clk, rst, rt_load, legacy_compat, rd_en, rd_valid, wr_en, wr_refused, pos_load;
	logic [31:0] rt_hours;
	logic [7:0] rt_minutes;
	logic [3:0] dev_rx_ok, dev_compat;
	logic [15:0] rd_addr, wr_addr, wr_data, act_pos_raw, act_closed_end;
	bsr_word_t rd_data;
	bsr_pos_t act_pos_rel;
	int n_errors = 0;
	int tests_run = 0;
	bsr_status_map #(.REFRESH_CYC(32'd20), .STALE_CYC(32'd100)) bsr_status_map_i (.clk(clk),
		.rst(rst), .rt_load(rt_load), .rt_hours(rt_hours), .rt_minutes(rt_minutes),
		.dev_rx_ok(dev_rx_ok), .dev_compat(dev_compat), .legacy_compat(legacy_compat),
		.rd_en(rd_en), .rd_addr(rd_addr), .rd_valid(rd_valid), .rd_data(rd_data),
		.wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data), .wr_refused(wr_refused),
		.pos_load(pos_load), .act_pos_raw(act_pos_raw), .act_closed_end(act_closed_end),
		.act_pos_rel(act_pos_rel));
	bsr_master_model bsr_master_model_i (.clk(clk), .rd_en(rd_en), .rd_addr(rd_addr),
		.rd_valid(rd_valid), .rd_data(rd_data));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", n, exp, got);
		end
	endtask
	task automatic rchk(input logic [15:0] a, input bsr_word_t e);
		bsr_word_t d;
		logic ok;
		bsr_master_model_i.rd(a, d, ok);
		chk("rd_valid", ok, 1'b1);
		chk("rd_data", d, e);
	endtask
	task automatic t_reset();
		for (int a = 16'h01b4; a <= 16'h01bb; a++) rchk(16'(a), 16'h0000);
		chk("wr_refused", wr_refused, 1'b0);
		chk("act_pos_rel", act_pos_rel, 12'h000);
		$display("reset values done");
	endtask
	task automatic t_runtime();
		dev_rx_ok = 4'hf;
		dev_compat = 4'ha;
		legacy_compat = 1'b1;
		rt_hours = 32'h1234_abcd;
		rt_minutes = 8'h5a;
		rt_load = 1'b1;
		@(negedge clk);
		rt_load = 1'b0;
		rchk(16'h01b4, 16'h1234);
		rchk(16'h01b5, 16'habcd);
		rchk(16'h01b6, 16'h5a00);
		rchk(16'h01b8, 16'h0000);
		repeat (25) @(negedge clk);
		rchk(16'h01b9, 16'h0001);
		rchk(16'h01ba, 16'h000f);
		rchk(16'h01bb, 16'h010a);
		$display("runtime and refresh done");
	endtask
	task automatic t_stale();
		dev_compat = 4'h5;
		legacy_compat = 1'b0;
		repeat (110) @(negedge clk);
		rchk(16'h01b9, 16'h0000);
		rchk(16'h01ba, 16'h000d);
		rchk(16'h01bb, 16'h0005);
		wr_en = 1'b1;
		wr_addr = 16'h01b4;
		wr_data = 16'hffff;
		@(negedge clk);
		wr_en = 1'b0;
		chk("wr_refused", wr_refused, 1'b1);
		rchk(16'h01b4, 16'h1234);
		$display("stale and write done");
	endtask
	task automatic t_pos();
		logic [15:0] r[3] = '{16'h0100, 16'h0010, 16'h2000};
		logic [15:0] c[3] = '{16'h0040, 16'h0040, 16'h0000};
		bsr_pos_t e[3] = '{12'h0c0, 12'h000, 12'hfff};
		pos_load = 1'b1;
		for (int i = 0; i < 3; i++) begin
			act_pos_raw = r[i];
			act_closed_end = c[i];
			@(negedge clk);
			chk("act_pos_rel", act_pos_rel, e[i]);
		end
		pos_load = 1'b0;
		act_pos_raw = 16'h0000;
		@(negedge clk);
		chk("act_pos_rel held", act_pos_rel, 12'hfff);
		$display("position done");
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		{rst, rt_load, legacy_compat, wr_en, pos_load} = 5'h10;
		{rt_hours, rt_minutes, dev_rx_ok, dev_compat} = 48'h0;
		{wr_addr, wr_data, act_pos_raw, act_closed_end} = 64'h0;
		repeat (8) @(negedge clk);
		rst = 1'b0;
		t_reset();
		t_runtime();
		t_stale();
		t_pos();
		final_report();
	end
	initial begin
		repeat (2000) @(negedge clk);
		n_errors++;
		final_report();
	end
endmodule // testbench
`default_nettype wire
